// File: dv/pptfc_core_chk.sv
`timescale 1ns/10ps
// checks on the core's ports
module pptfc_core_chk
    import pptfc_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       ioWrite,
    input wire logic       memAccess,
    input wire logic       vgaIoAccess,
    input wire logic       extAccess,
    input wire logic       dotClockTick,
    input wire logic       stnPanel,
    input wire logic       generalPinZeroOut,
    input wire logic       generalPinZeroOe,
    input wire logic       backlightEnablePin,
    input wire logic       panelOffRequest,
    input wire logic [1:0] colourMode,
    input wire logic [1:0] driveType,
    input wire logic       formatValid,
    input wire logic [5:0] pixelsThirds,
    input wire logic [4:0] maxBpp,
    input wire logic       panelShiftStrobe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // waking accesses
    sequence accessSeq;
        memAccess || vgaIoAccess || extAccess;
    endsequence
    // expiry on either action
    sequence expirySeq;
        $fell(backlightEnablePin) || $rose(panelOffRequest);
    endsequence
    chk_strobe_needs_tick: assert property (panelShiftStrobe |-> $past(dotClockTick))
        else $error("strobe without tick");
    chk_one_action: assert property (!(panelOffRequest && !backlightEnablePin))
        else $error("two actions");
    chk_backlight_wake: assert property (
        !backlightEnablePin ##0 accessSeq |=> backlightEnablePin)
        else $error("backlight kept");
    chk_paneloff_wake: assert property (
        panelOffRequest ##0 accessSeq |=> !panelOffRequest)
        else $error("panel off kept");
    chk_quiet_expiry: assert property (
        expirySeq |-> !$past(memAccess) && !$past(vgaIoAccess))
        else $error("expiry after reload");
    chk_input_pin_low: assert property (!generalPinZeroOe |-> !generalPinZeroOut)
        else $error("input pin driven");
    chk_format_by_write: assert property (
        !$stable({colourMode, driveType}) |-> $past(ioWrite) || $past(ioWrite, 2))
        else $error("format moved");
    chk_mono_tft: assert property (
        (!stnPanel && colourMode != COLOUR_PANEL && formatValid)
        |-> maxBpp == ((pixelsThirds <= 6'd6) ? 5'd8 : 5'(48 / pixelsThirds)))
        else $error("mono tft depth wrong");
    chk_colour_tft: assert property (
        (!stnPanel && colourMode == COLOUR_PANEL && formatValid)
        |-> {pixelsThirds, maxBpp} inside {{6'd3, 5'd24}, {6'd6, 5'd12}})
        else $error("colour tft format wrong");
    chk_mono_stn_dual: assert property (
        (stnPanel && colourMode != COLOUR_PANEL && driveType != DRIVE_DUAL) |-> !formatValid)
        else $error("mono stn ss valid");
endmodule
bind pptfc_core pptfc_core_chk pptfc_core_chk_i (
    .clock(clock), .rst_n(rst_n), .ioWrite(ioWrite), .memAccess(memAccess),
    .vgaIoAccess(vgaIoAccess), .extAccess(extAccess), .dotClockTick(dotClockTick),
    .stnPanel(stnPanel), .generalPinZeroOut(generalPinZeroOut),
    .generalPinZeroOe(generalPinZeroOe), .backlightEnablePin(backlightEnablePin),
    .panelOffRequest(panelOffRequest), .colourMode(colourMode), .driveType(driveType),
    .formatValid(formatValid), .pixelsThirds(pixelsThirds), .maxBpp(maxBpp),
    .panelShiftStrobe(panelShiftStrobe));

// File: dv/pptfc_core_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
$display("MISMATCH %0t got %0h exp %0h", $time, (a), (b)); end end
module pptfc_core_tb_top;
    import pptfc_pkg::*;
    localparam int STEPS = 2;          // short timer step
    localparam int PS    = PSCLK_DIV;  // clocks per timer tick
    int          mismatches = 0;
    int          compares = 0;
    int          t, v, p, b, d, tk, sc, shifts;
    logic [15:0] lfsr = 16'h3868;      // seed 14440
    logic [15:0] r;
    logic [7:0]  rv;
    logic [1:0]  col, cMode, dType;
    logic [7:0]  ix [3] = '{PIN_ROLE_IDX, TIMER_CTRL_IDX, FORMAT_ZERO_IDX};
    logic [7:0]  mdl [3] = '{PIN_ROLE_RST, TIMER_CTRL_RST, FORMAT_ZERO_RST};
    logic        clock = 1'b0, rst_n = 1'b0, ioRead = 1'b0, ioWrite = 1'b0;
    logic [15:0] ioAddr = 16'h0000;
    logic [7:0]  ioWriteData = 8'h00, ioReadData;
    logic        memAccess = 1'b0, vgaIoAccess = 1'b0, extAccess = 1'b0;
    logic        compositeSync = 1'b0, dotClockTick = 1'b0, stnPanel = 1'b0;
    logic        frameAccel = 1'b0, colourPack4 = 1'b0, oneDrv = 1'b0, zeroDrv = 1'b0;
    logic        oneOut, oneOe, zeroOut, zeroOe, blPin, offReq, fmtOk, strobe, lit;
    logic [5:0]  pix3;
    logic [4:0]  bpp;
    // pin: core when driving, else bench
    wire logic   pinOne = oneOe ? oneOut : oneDrv;
    wire logic   pinZero = zeroOe ? zeroOut : zeroDrv;
    always #25 clock = ~clock;
    pptfc_core #(.STEP_CYCLES(STEPS)) pptfc_core_i (
        .clock(clock), .rst_n(rst_n), .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite),
        .ioWriteData(ioWriteData), .ioReadData(ioReadData), .memAccess(memAccess),
        .vgaIoAccess(vgaIoAccess), .extAccess(extAccess), .compositeSync(compositeSync),
        .dotClockTick(dotClockTick), .stnPanel(stnPanel), .frameAccel(frameAccel),
        .colourPack4(colourPack4), .generalPinOneIn(pinOne), .generalPinOneOut(oneOut),
        .generalPinOneOe(oneOe), .generalPinZeroIn(pinZero), .generalPinZeroOut(zeroOut),
        .generalPinZeroOe(zeroOe), .backlightEnablePin(blPin), .panelOffRequest(offReq),
        .colourMode(cMode), .driveType(dType), .formatValid(fmtOk), .pixelsThirds(pix3),
        .maxBpp(bpp), .panelShiftStrobe(strobe));
    pptfc_panel_model pptfc_panel_model_i (
        .clock(clock), .rst_n(rst_n), .panelShiftStrobe(strobe), .backlightEnablePin(blPin),
        .panelOffRequest(offReq), .shiftCount(shifts), .panelLit(lit));
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    // expected format from the rules
    function automatic void fmtExp(input int s, a, p4, c, dl, k, output int ok, px, bp);
        int lo = 0, hi = -1, p0 = 3, b0 = 0;
        if (!s) begin
            hi = (c == 3) ? 1 : 4;
        end else if (dl == 3) begin
            lo = !a;  // no acceleration forbids the undivided clock
            hi = lo + ((c != 3) ? 3 : (p4 ? 1 : 2));
            p0 = (c != 3) ? (a ? 3 : 6) : (p4 ? 8 : 6);
            b0 = (c != 3) ? 2 : p0;
        end else if (c == 3 && p4) begin
            hi = 2;
            p0 = 4;
            b0 = 4;
        end
        ok = (k >= lo && k <= hi);
        px = p0 << (k - lo);
        bp = s ? b0 << (k - lo) : (c == 3) ? 24 >> k : (k == 0) ? 8 : 16 >> k;
    endfunction
    task automatic test_done();
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] dv);
        @(posedge clock);
        ioAddr <= a;
        ioWriteData <= dv;
        ioWrite <= 1'b1;
        @(posedge clock);
        ioWrite <= 1'b0;
    endtask
    // indexed write; e picks the extension space
    task automatic sg(input logic e, input logic [7:0] i, input logic [7:0] dv);
        wr(e ? EXT_INDEX_ADDR : PANEL_INDEX_ADDR, i);
        wr(e ? EXT_DATA_ADDR : PANEL_DATA_ADDR, dv);
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic rg(input logic e, input logic [7:0] i, output logic [7:0] dv);
        wr(e ? EXT_INDEX_ADDR : PANEL_INDEX_ADDR, i);
        @(posedge clock);
        ioAddr <= e ? EXT_DATA_ADDR : PANEL_DATA_ADDR;
        ioRead <= 1'b1;
        @(posedge clock);
        ioRead <= 1'b0;
        @(posedge clock);
        #1 dv = ioReadData;
    endtask
    // one-cycle access pulse {ext, vga, mem}
    task automatic pulse(input logic [2:0] m);
        @(posedge clock);
        {extAccess, vgaIoAccess, memAccess} <= m;
        @(posedge clock);
        {extAccess, vgaIoAccess, memAccess} <= 3'b000;
        #1;
    endtask
    // bounded wait for expiry
    task automatic waitExp(output int n);
        n = 0;
        while (blPin === 1'b1 && offReq === 1'b0 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 20000) begin
            mismatches++;
            test_done();
        end
        #1;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        #1 `CHK({blPin, offReq, oneOe, zeroOe}, 4'b1001)
        for (int k = 0; k < 9; k++) begin
            if (k >= 3) begin
                r = rnd();
                mdl[k % 3] = (k % 3 == 1) ? r[7:0] & 8'h7f : r[7:0];
                sg(0, ix[k % 3], mdl[k % 3]);
            end
            rg(0, ix[k % 3], rv);
            `CHK(rv, mdl[k % 3])
        end
        sg(0, 8'h3e, 8'h5a);  // unmapped index: dropped
        rg(0, 8'h3e, rv);
        `CHK(rv, 8'h00)
        // both pins driven from pin data
        sg(0, PIN_ROLE_IDX, 8'hd8);
        sg(1, PIN_DATA_IDX, 8'h02);
        `CHK({oneOe, oneOut, zeroOe, zeroOut}, 4'b1110)
        sg(0, PIN_ROLE_IDX, 8'h90);
        @(posedge clock);
        r = rnd();
        {oneDrv, zeroDrv} <= r[1:0];
        rg(1, PIN_DATA_IDX, rv);
        `CHK({rv[1:0], oneOe, zeroOe}, {r[1:0], 2'b00})
        sg(0, PIN_ROLE_IDX, 8'h08);
        repeat (4) begin
            @(posedge clock);
            r = rnd();
            compositeSync <= r[0];
            #1 `CHK({zeroOe, zeroOut}, {1'b1, r[0]})
        end
        sg(0, PIN_ROLE_IDX, 8'h00);
        pulse(3'b001);
        `CHK({oneOe, zeroOut}, 2'b01)
        // one step, backlight action
        sg(0, TIMER_CTRL_IDX, 8'h80);
        pulse(3'b001);
        waitExp(t);
        `CHK(t >= (STEPS - 1) * PS - 4 && t <= STEPS * PS + 4, 1'b1)
        `CHK({blPin, offReq, lit}, 3'b000)
        pulse(3'b001);
        @(posedge clock);
        #1 `CHK(blPin, 1'b1)
        // two steps, panel off; ext access mid-run
        sg(0, TIMER_CTRL_IDX, 8'hc1);
        pulse(3'b001);
        repeat (2 * PS) @(posedge clock);
        pulse(3'b100);
        waitExp(t);
        t += 2 * PS + 2;
        `CHK(t >= (2 * STEPS - 1) * PS - 4 && t <= 2 * STEPS * PS + 4, 1'b1)
        `CHK({blPin, offReq}, 2'b11)
        pulse(3'b010);
        @(posedge clock);
        #1 `CHK(offReq, 1'b0)
        repeat (2 * PS) @(posedge clock);
        pulse(3'b010);
        waitExp(t);
        `CHK(t >= (2 * STEPS - 1) * PS - 4 && t <= 2 * STEPS * PS + 4, 1'b1)
        pulse(3'b100);
        @(posedge clock);
        #1 `CHK(offReq, 1'b0)
        sg(0, TIMER_CTRL_IDX, 8'h9f);
        waitExp(t);
        `CHK(t <= 4, 1'b1)
        // timer on the slow pin: two rising edges end one step
        sg(1, CLK_SELECT_IDX, 8'h08);
        sg(0, TIMER_CTRL_IDX, 8'h80);
        repeat (4) @(posedge clock) oneDrv <= ~oneDrv;
        repeat (2) @(posedge clock);
        #1 `CHK(blPin, 1'b0)
        sg(0, TIMER_CTRL_IDX, 8'h1f);
        repeat (2 * PS) @(posedge clock);
        #1 `CHK({blPin, offReq}, 2'b10)
        // every panel type against every divide code
        for (int k = 0; k < 256; k++) begin
            r = rnd();
            col = k[4] ? 2'h3 : 2'(r % 3);
            d = (k[7] && k[3]) ? 3 : 0;
            @(posedge clock);
            {stnPanel, frameAccel, colourPack4} <= 3'(k >> 5);
            sg(0, FORMAT_ZERO_IDX, {1'b0, 3'(k), col, 2'(d)});
            fmtExp(k[7], k[6], k[5], col, d, k % 8, v, p, b);
            `CHK({cMode, dType, fmtOk}, {col, 2'(d), 1'(v)})
            if (v != 0) begin
                `CHK({pix3, bpp}, {6'(p), 5'(b)})
            end
        end
        @(posedge clock);
        stnPanel <= 1'b0;
        // strobes per random dot ticks, mono tft
        for (int k = 0; k < 8; k++) begin
            sg(0, FORMAT_ZERO_IDX, {1'b0, 3'(k), 4'h0});
            tk = 0;
            sc = shifts;
            repeat (256) begin
                @(posedge clock);
                r = rnd();
                dotClockTick <= r[0];
                tk += r[0];
            end
            @(posedge clock);
            dotClockTick <= 1'b0;
            repeat (2) @(posedge clock);
            #1 d = shifts - sc - ((k <= 4) ? (tk >> k) : 0);
            `CHK(d >= -1 && d <= 1, 1'b1)
        end
        test_done();
    end
endmodule

// File: dv/pptfc_panel_model.sv
`timescale 1ns/10ps
// panel side: takes one pixel group per shift strobe
module pptfc_panel_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic panelShiftStrobe,
    input  wire logic backlightEnablePin,
    input  wire logic panelOffRequest,
    output int        shiftCount,
    output logic      panelLit
);
    // groups taken so far
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shiftCount <= 0;
        end else if (panelShiftStrobe) begin
            shiftCount <= shiftCount + 1;
        end
    end
    // picture shows with backlight on, panel on
    assign panelLit = backlightEnablePin && !panelOffRequest;
endmodule

// File: verilog/pptfc_core.sv
`timescale 1ns/10ps
// Summary of operation
// - pin one role: slow clock, input, output
// - pin zero role: activity, sync, input, output
// - timer enable bit, cleared at reset
// - expiry: backlight off or panel off
// - step per count, zero is one step
// - all-ones count gives no delay
// - memory or vga access reloads the timer
// - extended register access leaves timer alone
// - any access after expiry restarts, cancels action
// - timer ticks on power sequencing clock
// - colour handling select field
// - panel drive type field
// - shift clock ratio field, reset zero
// - mono tft: divide 1 to 16
// - colour tft: divide 1 or 2
// - mono dual stn accel: divide 1 to 8
// - 4-bit dual stn accel: divide 1, 2
// - 3-bit dual stn accel: divide 1 to 4
// - 4-bit single stn: divide 1 to 4
// - mono dual stn plain: 2 to 16
// - 4-bit dual stn plain: 2 or 4
// - 3-bit dual stn plain: 2 to 8
// - clock select bit picks timer clock source
module pptfc_core
    import pptfc_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_TICKS
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [15:0] ioAddr,            // host i/o address
    input  wire logic        ioRead,            // read strobe, one cycle
    input  wire logic        ioWrite,           // write strobe, one cycle
    input  wire logic [7:0]  ioWriteData,
    output logic      [7:0]  ioReadData,        // valid the cycle after ioRead
    input  wire logic        memAccess,         // graphics memory access pulse
    input  wire logic        vgaIoAccess,       // standard vga i/o access pulse
    input  wire logic        extAccess,         // other extended register access
    input  wire logic        compositeSync,
    input  wire logic        dotClockTick,      // one pulse per dot clock
    input  wire logic        stnPanel,          // panel is stn, not tft
    input  wire logic        frameAccel,        // frame acceleration on
    input  wire logic        colourPack4,       // 4-bit packing, else 3-bit
    input  wire logic        generalPinOneIn,
    output logic             generalPinOneOut,
    output logic             generalPinOneOe,
    input  wire logic        generalPinZeroIn,
    output logic             generalPinZeroOut,
    output logic             generalPinZeroOe,
    output logic             backlightEnablePin,
    output logic             panelOffRequest,
    output logic [1:0]       colourMode,
    output logic [1:0]       driveType,
    output logic             formatValid,
    output logic [5:0]       pixelsThirds,      // pixels per shift, in thirds
    output logic [4:0]       maxBpp,
    output logic             panelShiftStrobe   // one pulse per shift clock
);

    // all state of the block
    typedef struct packed {
        logic [7:0]  panelIndex;     // index for panel space
        logic [7:0]  extIndex;       // index for extension space
        logic [7:0]  pinRole;
        logic [7:0]  timerCtrl;
        logic [7:0]  formatZero;
        logic [1:0]  pinData;
        logic [7:0]  clkSelect;
        logic [7:0]  readData;
        logic [9:0]  divCnt;         // power sequencing divider
        logic [20:0] tickCnt;        // ticks inside one step
        logic [4:0]  stepCnt;        // steps elapsed
        logic        expired;
        logic        slowPrev;       // last sample of the slow clock pin
        logic        activity;       // registered activity indication
        logic [3:0]  shiftCnt;
        logic        shiftStrobe;
    } pptfc_state_t;

    pptfc_state_t cur;                           // registered state
    pptfc_state_t next_cur;                      // next state
    pptfc_fmt_t   fmt;                           // current format answer

    // format table; divide is 2**code, range and load vary
    function automatic pptfc_fmt_t formatLookup(
        input logic       colour,
        input logic       dual,
        input logic       stn,
        input logic       accel,
        input logic       pack4,
        input logic [2:0] code
    );
        pptfc_fmt_t r;
        logic [5:0] one;
        r   = '0;
        one = 6'h01 << code;
        if (!stn && !colour) begin
            r.valid     = (code <= 3'h4);
            r.pixThirds = 6'(3 * one);
            r.maxBpp    = (code <= 3'h1) ? 5'h08 : 5'(16 >> code);
        end else if (!stn) begin
            r.valid     = (code <= 3'h1);
            r.pixThirds = 6'(3 * one);
            r.maxBpp    = (code == 3'h0) ? 5'h18 : 5'h0c;
        end else if (!colour) begin
            if (accel) begin
                r.valid  = dual && (code <= 3'h3);
                r.maxBpp = 5'(2 * one);
            end else begin
                r.valid  = dual && (code != 3'h0) && (code <= 3'h4);
                r.maxBpp = 5'(one);
            end
            r.pixThirds = 6'(3 * one);
        end else if (!dual) begin
            r.valid     = pack4 && (code <= 3'h2);
            r.pixThirds = 6'(4 * one);
            r.maxBpp    = 5'(4 * one);
        end else if (pack4) begin
            if (accel) begin
                r.valid     = (code <= 3'h1);
                r.pixThirds = 6'(8 * one);
                r.maxBpp    = 5'(8 * one);
            end else begin
                r.valid     = (code != 3'h0) && (code <= 3'h2);
                r.pixThirds = 6'(4 * one);
                r.maxBpp    = 5'(4 * one);
            end
        end else begin
            if (accel) begin
                r.valid     = (code <= 3'h2);
                r.pixThirds = 6'(6 * one);
                r.maxBpp    = 5'(6 * one);
            end else begin
                r.valid     = (code != 3'h0) && (code <= 3'h3);
                r.pixThirds = 6'(3 * one);
                r.maxBpp    = 5'(3 * one);
            end
        end
        return r;
    endfunction

    logic [1:0] pinOneRole;
    logic [1:0] pinZeroRole;
    logic [2:0] shiftCode;
    logic       panelWr;
    logic       extWr;
    logic       ownAccess;                       // any access to our ports
    logic       reload;
    logic       psTick;                          // power sequencing clock tick
    logic [4:0] timerCount;
    logic [3:0] divMask;

    assign pinOneRole  = cur.pinRole[PIN_ONE_ROLE_LSB +: 2];
    assign pinZeroRole = cur.pinRole[PIN_ZERO_ROLE_LSB +: 2];
    assign shiftCode   = cur.formatZero[SHIFT_DIV_LSB +: 3];
    assign timerCount  = cur.timerCtrl[TIMER_COUNT_LSB +: 5];
    assign panelWr     = ioWrite && (ioAddr == PANEL_DATA_ADDR);
    assign extWr       = ioWrite && (ioAddr == EXT_DATA_ADDR);
    assign ownAccess   = (ioRead || ioWrite) &&
                         (ioAddr == PANEL_INDEX_ADDR || ioAddr == PANEL_DATA_ADDR ||
                          ioAddr == EXT_INDEX_ADDR || ioAddr == EXT_DATA_ADDR);
    // extended register traffic never reloads
    assign reload      = memAccess || vgaIoAccess;
    // tick: internal divider or slow pin
    assign psTick      = cur.clkSelect[CLK_SELECT_BIT] ?
                         (pinOneRole == ROLE_DEFAULT && generalPinOneIn &&
                          !cur.slowPrev) :
                         (cur.divCnt == 10'(PSCLK_DIV - 1));
    assign divMask     = 4'(5'h01 << shiftCode) - 4'h1;
    assign fmt         = formatLookup(colourMode == COLOUR_PANEL,
                                      driveType == DRIVE_DUAL,
                                      stnPanel, frameAccel, colourPack4, shiftCode);

    // next-state logic
    always_comb begin
        next_cur          = cur;
        next_cur.slowPrev = generalPinOneIn;
        next_cur.activity = memAccess || vgaIoAccess;
        // index and data ports
        if (ioWrite && ioAddr == PANEL_INDEX_ADDR) begin
            next_cur.panelIndex = ioWriteData;
        end
        if (ioWrite && ioAddr == EXT_INDEX_ADDR) begin
            next_cur.extIndex = ioWriteData;
        end
        if (panelWr) begin
            unique case (cur.panelIndex)
                PIN_ROLE_IDX:    next_cur.pinRole    = ioWriteData;
                TIMER_CTRL_IDX:  next_cur.timerCtrl  = ioWriteData;
                FORMAT_ZERO_IDX: next_cur.formatZero = ioWriteData;
                default: ;                                          // unmapped: ignored
            endcase
        end
        if (extWr) begin
            unique case (cur.extIndex)
                PIN_DATA_IDX:   next_cur.pinData   = ioWriteData[1:0];
                CLK_SELECT_IDX: next_cur.clkSelect = ioWriteData;
                default: ;
            endcase
        end
        // read data a cycle later; unmapped reads zero
        if (ioRead) begin
            next_cur.readData = 8'h00;
            unique case (ioAddr)
                PANEL_INDEX_ADDR: next_cur.readData = cur.panelIndex;
                EXT_INDEX_ADDR:   next_cur.readData = cur.extIndex;
                PANEL_DATA_ADDR: begin
                    unique case (cur.panelIndex)
                        PIN_ROLE_IDX:    next_cur.readData = cur.pinRole;
                        TIMER_CTRL_IDX:  next_cur.readData = cur.timerCtrl;
                        FORMAT_ZERO_IDX: next_cur.readData = cur.formatZero;
                        default:         next_cur.readData = 8'h00;
                    endcase
                end
                EXT_DATA_ADDR: begin
                    unique case (cur.extIndex)
                        PIN_DATA_IDX: begin
                            // input roles read the pin
                            next_cur.readData[1] = (pinOneRole == ROLE_INPUT) ?
                                                   generalPinOneIn : cur.pinData[1];
                            next_cur.readData[0] = (pinZeroRole == ROLE_INPUT) ?
                                                   generalPinZeroIn : cur.pinData[0];
                        end
                        CLK_SELECT_IDX: next_cur.readData = cur.clkSelect;
                        default:        next_cur.readData = 8'h00;
                    endcase
                end
                default: next_cur.readData = 8'h00;
            endcase
        end
        // power sequencing divider runs freely
        next_cur.divCnt = (cur.divCnt == 10'(PSCLK_DIV - 1)) ? 10'h000 : cur.divCnt + 10'h001;
        // activity timer
        if (!cur.timerCtrl[TIMER_EN_BIT]) begin
            next_cur.expired = 1'b0;
            next_cur.tickCnt = '0;
            next_cur.stepCnt = '0;
        end else if (cur.expired) begin
            // any access wakes and restarts
            if (reload || extAccess || ownAccess) begin
                next_cur.expired = 1'b0;
                next_cur.tickCnt = '0;
                next_cur.stepCnt = '0;
            end
        end else if (reload) begin
            next_cur.tickCnt = '0;
            next_cur.stepCnt = '0;
        end else if (timerCount == TIMER_NO_DELAY) begin
            next_cur.expired = 1'b1;
        end else if (psTick) begin
            if (cur.tickCnt == 21'(STEP_CYCLES - 1)) begin
                next_cur.tickCnt = '0;
                if (cur.stepCnt == timerCount) begin
                    next_cur.expired = 1'b1;
                end else begin
                    next_cur.stepCnt = cur.stepCnt + 5'h01;
                end
            end else begin
                next_cur.tickCnt = cur.tickCnt + 21'h000001;
            end
        end
        // shift strobe every 2**code dot clocks; held quiet on bad codes
        next_cur.shiftStrobe = 1'b0;
        if (!fmt.valid) begin
            next_cur.shiftCnt = 4'h0;
        end else if (dotClockTick) begin
            if ((cur.shiftCnt & divMask) == divMask) begin
                next_cur.shiftCnt    = 4'h0;
                next_cur.shiftStrobe = 1'b1;
            end else begin
                next_cur.shiftCnt = cur.shiftCnt + 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur            <= '0;
            cur.pinRole    <= PIN_ROLE_RST;
            cur.timerCtrl  <= TIMER_CTRL_RST;
            cur.formatZero <= FORMAT_ZERO_RST;
            cur.pinData    <= PIN_DATA_RST;
            cur.clkSelect  <= CLK_SELECT_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // pin one: only the output role drives the pin
    assign generalPinOneOe    = (pinOneRole == ROLE_OUTPUT);
    assign generalPinOneOut   = cur.pinData[1];
    // pin zero: input role releases it
    assign generalPinZeroOe   = (pinZeroRole != ROLE_INPUT);
    always_comb begin
        unique case (pinZeroRole)
            ROLE_DEFAULT: generalPinZeroOut = cur.activity;
            ROLE_ALT:     generalPinZeroOut = compositeSync;
            ROLE_INPUT:   generalPinZeroOut = 1'b0;
            ROLE_OUTPUT:  generalPinZeroOut = cur.pinData[0];
        endcase
    end

    // timeout action, dropped on restart
    assign backlightEnablePin = !(cur.expired && !cur.timerCtrl[TIMER_ACTION_BIT]);
    assign panelOffRequest    = cur.expired && cur.timerCtrl[TIMER_ACTION_BIT];
    assign colourMode         = cur.formatZero[COLOUR_SEL_LSB +: 2];
    assign driveType          = cur.formatZero[DRIVE_TYPE_LSB +: 2];
    assign formatValid        = fmt.valid;
    assign pixelsThirds       = fmt.pixThirds;
    assign maxBpp             = fmt.maxBpp;
    assign panelShiftStrobe   = cur.shiftStrobe;
    assign ioReadData         = cur.readData;

endmodule

// File: verilog/pptfc_pkg.sv
package pptfc_pkg;
    // host port addresses of the two indexed register spaces
    localparam logic [15:0] PANEL_INDEX_ADDR = 16'h03d0;
    localparam logic [15:0] PANEL_DATA_ADDR  = 16'h03d1;
    localparam logic [15:0] EXT_INDEX_ADDR   = 16'h03d6;
    localparam logic [15:0] EXT_DATA_ADDR    = 16'h03d7;
    // panel register indices
    localparam logic [7:0] PIN_ROLE_IDX      = 8'h0c;
    localparam logic [7:0] TIMER_CTRL_IDX    = 8'h0f;
    localparam logic [7:0] FORMAT_ZERO_IDX   = 8'h10;
    // extension register indices
    localparam logic [7:0] PIN_DATA_IDX      = 8'h63;
    localparam logic [7:0] CLK_SELECT_IDX    = 8'hcf;
    // reset values
    localparam logic [7:0] PIN_ROLE_RST      = 8'h00;
    localparam logic [7:0] TIMER_CTRL_RST    = 8'h00;
    localparam logic [7:0] FORMAT_ZERO_RST   = 8'h00;
    localparam logic [1:0] PIN_DATA_RST      = 2'h0;
    localparam logic [7:0] CLK_SELECT_RST    = 8'h00;
    // field positions
    localparam int PIN_ONE_ROLE_LSB  = 6;
    localparam int PIN_ZERO_ROLE_LSB = 3;
    localparam int TIMER_EN_BIT      = 7;
    localparam int TIMER_ACTION_BIT  = 6;
    localparam int TIMER_COUNT_LSB   = 0;
    localparam int SHIFT_DIV_LSB     = 4;
    localparam int COLOUR_SEL_LSB    = 2;
    localparam int DRIVE_TYPE_LSB    = 0;
    localparam int CLK_SELECT_BIT    = 3;
    // pin role codes
    localparam logic [1:0] ROLE_DEFAULT = 2'h0;
    localparam logic [1:0] ROLE_ALT     = 2'h1;
    localparam logic [1:0] ROLE_INPUT   = 2'h2;
    localparam logic [1:0] ROLE_OUTPUT  = 2'h3;
    // colour, drive and timer codes
    localparam logic [1:0] COLOUR_PANEL = 2'h3;
    localparam logic [1:0] DRIVE_DUAL   = 2'h3;
    localparam logic [4:0] TIMER_NO_DELAY = 5'h1f;
    // timing
    localparam int CLK_HZ        = 20000000;
    localparam int PSCLK_HZ      = 37500;
    localparam int STEP_MS       = 28100;
    localparam int PSCLK_DIV     = CLK_HZ / PSCLK_HZ;
    localparam int STEP_TICKS    = (STEP_MS / 100) * (PSCLK_HZ / 10);
    // answer of the format lookup
    typedef struct packed {
        logic       valid;
        logic [5:0] pixThirds;
        logic [4:0] maxBpp;
    } pptfc_fmt_t;
endpackage
